// [btu_uart_top.sv]
// Bit-timed UART transmitter and receiver with an AHB-Lite register slave.
//
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`include "btu_map.svh"
module btu_uart_top
  import btu_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = `BTU_BIT_CYCLES,
  parameter int unsigned DEPTH      = 16
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        serial_in_line,
  output logic             serial_out_line
);
  localparam int unsigned AW = $clog2(DEPTH);

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  // Start at bit 0, character above it, then parity, then stop; unused upper bits idle.
  function automatic logic [15:0] build_tx(input logic [7:0] ch, input btu_cfg_s c);
    logic [15:0] f;
    logic [7:0]  d;
    f = `BTU_FRAME_IDLE;
    d = c.lsb_first ? ch : rev8(ch);
    f[0] = 1'b0;
    f[8:1] = d;
    case (c.parity)
      BTU_PAR_LOW:  f[9] = 1'b0;
      BTU_PAR_ODD:  f[9] = ~^d;
      BTU_PAR_EVEN: f[9] = ^d;
      default:      f[9] = 1'b1;
    endcase
    return c.invert ? ~f : f;
  endfunction

  btu_cfg_s       cfg_ff;
  logic [15:0]    interval_ff;
  logic [7:0]     tx_len_ff;
  logic [7:0]     rx_len_ff;
  logic [7:0]     txbuf_ff [DEPTH];
  logic [7:0]     rxbuf_ff [DEPTH];
  logic           wr_pend_ff;
  logic [7:0]     wr_addr_ff;
  logic [31:0]    hrdata_ff;
  btu_tx_state_e  tx_state_ff;
  logic [15:0]    tx_frame_ff;
  logic [3:0]     tx_left_ff;
  logic [AW-1:0]  tx_idx_ff;
  logic [7:0]     tx_sent_ff;
  logic           tx_done_ff;
  logic           serial_out_ff;
  btu_rx_state_e  rx_state_ff;
  logic [15:0]    rx_frame_ff;
  logic [3:0]     rx_bits_ff;
  logic [AW-1:0]  rx_idx_ff;
  logic [7:0]     rx_cnt_ff;
  logic           rx_done_ff;
  logic           framing_err_ff;
  logic           parity_err_ff;
  logic           rx_line_ff;
  btu_timer_ctl_s tx_ctl;
  btu_timer_ctl_s rx_ctl;
  logic           tx_tick_event;
  logic           rx_tick_event;
  logic           tx_running;
  logic           rx_running;

  // Zero-wait slave: read data is registered at the address phase edge.
  wire            addr_ok   = hsel & hready & htrans[1];
  wire [7:0]      ra        = haddr[7:0];
  wire [AW-1:0]   rd_idx    = ra[2 +: AW];
  wire [AW-1:0]   wr_idx    = wr_addr_ff[2 +: AW];
  wire            wr_ctrl   = wr_pend_ff & (wr_addr_ff == `BTU_OFF_CTRL);
  wire            wr_cmd    = wr_pend_ff & (wr_addr_ff == `BTU_OFF_CMD);
  wire            wr_txlen  = wr_pend_ff & (wr_addr_ff == `BTU_OFF_TX_LEN);
  wire            wr_rxlen  = wr_pend_ff & (wr_addr_ff == `BTU_OFF_RX_LEN);
  wire            wr_intv   = wr_pend_ff & (wr_addr_ff == `BTU_OFF_INTERVAL);
  wire            wr_txbuf  = wr_pend_ff & (wr_addr_ff[7:6] == `BTU_BUF_TX);
  wire            tx_busy   = tx_state_ff == BTU_TX_RUN;
  wire            rx_busy   = rx_state_ff != BTU_RX_IDLE;
  wire [31:0]     status_w  = {8'h00, tx_sent_ff, rx_cnt_ff, 2'b00, parity_err_ff,
                               framing_err_ff, rx_done_ff, rx_busy, tx_done_ff, tx_busy};
  wire [31:0]     rd_word   =
      (ra == `BTU_OFF_CTRL)      ? {28'h0000000, cfg_ff} :
      (ra == `BTU_OFF_STATUS)    ? status_w :
      (ra == `BTU_OFF_TX_LEN)    ? {24'h000000, tx_len_ff} :
      (ra == `BTU_OFF_RX_LEN)    ? {24'h000000, rx_len_ff} :
      (ra == `BTU_OFF_INTERVAL)  ? {16'h0000, interval_ff} :
      (ra[7:6] == `BTU_BUF_TX)   ? {24'h000000, txbuf_ff[rd_idx]} :
      (ra[7:6] == `BTU_BUF_RX)   ? {24'h000000, rxbuf_ff[rd_idx]} : 32'h00000000;

  assign hrdata          = hrdata_ff;
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign serial_out_line = serial_out_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff  <= 32'h00000000;
    end else begin
      wr_pend_ff <= addr_ok & hwrite;
      if (addr_ok) begin
        wr_addr_ff <= ra;
        hrdata_ff  <= hwrite ? 32'h00000000 : rd_word;
      end
    end
  end

  // Software writes the bit interval as clock frequency over baud rate.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_ff      <= btu_cfg_s'(`BTU_CTRL_RESET);
      interval_ff <= 16'(BIT_CYCLES);
      tx_len_ff   <= 8'h00;
      rx_len_ff   <= 8'h00;
    end else begin
      if (wr_ctrl) cfg_ff <= btu_cfg_s'(hwdata[`BTU_CTRL_INV:`BTU_CTRL_LSB]);
      if (wr_intv) interval_ff <= hwdata[15:0];
      if (wr_txlen) tx_len_ff <= hwdata[7:0];
      if (wr_rxlen) rx_len_ff <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk) begin
    if (wr_txbuf) txbuf_ff[wr_idx] <= hwdata[7:0];
  end

  // Transmitter.
  wire [3:0]    frame_bits = (cfg_ff.parity == BTU_PAR_NONE) ? `BTU_FRAME_NOPAR : `BTU_FRAME_PAR;
  wire [AW-1:0] tx_idx_inc = tx_idx_ff + {{(AW-1){1'b0}}, 1'b1};
  wire [15:0]   tx_first   = build_tx(txbuf_ff[0], cfg_ff);
  wire [15:0]   tx_next    = build_tx(txbuf_ff[tx_idx_inc], cfg_ff);
  wire          tx_go      = wr_cmd & hwdata[`BTU_CMD_TX] & ~tx_busy;
  wire          tx_step    = tx_busy & tx_tick_event;
  wire          tx_last    = tx_step & (tx_left_ff == 4'h1);
  wire          tx_more    = (tx_sent_ff + 8'h01) != tx_len_ff;

  assign tx_ctl.start      = (tx_go & (tx_len_ff != 8'h00)) | (tx_last & tx_more);
  assign tx_ctl.stop       = tx_last & ~tx_more;
  assign tx_ctl.start_load = interval_ff;
  assign tx_ctl.reload     = interval_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state_ff   <= BTU_TX_IDLE;
      tx_frame_ff   <= `BTU_FRAME_IDLE;
      tx_left_ff    <= 4'h0;
      tx_idx_ff     <= '0;
      tx_sent_ff    <= 8'h00;
      tx_done_ff    <= 1'b0;
      serial_out_ff <= 1'b1;
    end else if (tx_go) begin
      tx_sent_ff <= 8'h00;
      tx_idx_ff  <= '0;
      tx_done_ff <= tx_len_ff == 8'h00;
      if (tx_len_ff != 8'h00) begin
        tx_state_ff   <= BTU_TX_RUN;
        serial_out_ff <= tx_first[0];
        tx_frame_ff   <= {1'b0, tx_first[15:1]};
        tx_left_ff    <= frame_bits - 4'h1;
      end
    end else if (tx_step) begin
      serial_out_ff <= tx_frame_ff[0];
      tx_frame_ff   <= {1'b0, tx_frame_ff[15:1]};
      tx_left_ff    <= tx_left_ff - 4'h1;
      if (tx_left_ff == 4'h1) begin
        tx_sent_ff <= tx_sent_ff + 8'h01;
        tx_idx_ff  <= tx_idx_inc;
        if (tx_more) begin
          tx_frame_ff <= tx_next;
          tx_left_ff  <= frame_bits;
        end else begin
          tx_state_ff <= BTU_TX_IDLE;
          tx_done_ff  <= 1'b1;
        end
      end
    end else if (!tx_busy) begin
      serial_out_ff <= ~cfg_ff.invert;
    end
  end

  // Receiver. The line is taken as already synchronous to hclk.
  wire        rx_go      = wr_cmd & hwdata[`BTU_CMD_RX] & ~rx_busy;
  wire        rise       = serial_in_line & ~rx_line_ff;
  wire        fall       = ~serial_in_line & rx_line_ff;
  wire        start_edge_detect = (rx_state_ff == BTU_RX_ARMED) & (cfg_ff.invert ? fall : rise);
  wire        rx_step    = (rx_state_ff == BTU_RX_RECV) & rx_tick_event;
  wire [15:0] rx_shift   = {rx_frame_ff[14:0], serial_in_line};
  wire        rx_eval    = rx_step & ((rx_bits_ff + 4'h1) == frame_bits);
  wire [15:0] rx_fr      = cfg_ff.invert ? ~rx_shift : rx_shift;
  wire        has_par    = cfg_ff.parity != BTU_PAR_NONE;
  wire [7:0]  rx_raw     = has_par ? rx_fr[9:2] : rx_fr[8:1];
  wire [7:0]  rx_char    = cfg_ff.lsb_first ? rev8(rx_raw) : rx_raw;
  wire        rx_fe      = ~rx_fr[0];
  wire        par_chk    = (cfg_ff.parity == BTU_PAR_ODD) | (cfg_ff.parity == BTU_PAR_EVEN);
  wire        par_exp    = (cfg_ff.parity == BTU_PAR_ODD) ? ~^rx_char : ^rx_char;
  wire        rx_pe      = par_chk & (rx_fr[1] != par_exp);
  wire        rx_ok      = ~rx_fe & ~rx_pe;
  wire        rx_more    = (rx_cnt_ff + 8'h01) != rx_len_ff;

  assign rx_ctl.start      = start_edge_detect;
  assign rx_ctl.stop       = rx_eval;
  assign rx_ctl.start_load = {1'b0, interval_ff[15:1]};
  assign rx_ctl.reload     = interval_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rx_line_ff <= 1'b1;
    else rx_line_ff <= serial_in_line;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state_ff    <= BTU_RX_IDLE;
      rx_frame_ff    <= 16'h0000;
      rx_bits_ff     <= 4'h0;
      rx_idx_ff      <= '0;
      rx_cnt_ff      <= 8'h00;
      rx_done_ff     <= 1'b0;
      framing_err_ff <= 1'b0;
      parity_err_ff  <= 1'b0;
    end else if (rx_go) begin
      rx_state_ff    <= (rx_len_ff == 8'h00) ? BTU_RX_IDLE : BTU_RX_ARMED;
      rx_done_ff     <= rx_len_ff == 8'h00;
      framing_err_ff <= 1'b0;
      parity_err_ff  <= 1'b0;
      rx_cnt_ff      <= 8'h00;
      rx_idx_ff      <= '0;
    end else if (start_edge_detect) begin
      rx_state_ff <= BTU_RX_RECV;
      rx_bits_ff  <= 4'h0;
      rx_frame_ff <= 16'h0000;
    end else if (rx_step) begin
      rx_frame_ff <= rx_shift;
      rx_bits_ff  <= rx_bits_ff + 4'h1;
      if (rx_eval) begin
        framing_err_ff <= framing_err_ff | rx_fe;
        parity_err_ff  <= parity_err_ff | rx_pe;
        if (!rx_ok) begin
          rx_state_ff <= BTU_RX_IDLE;
        end else begin
          rx_idx_ff <= rx_idx_ff + {{(AW-1){1'b0}}, 1'b1};
          rx_cnt_ff <= rx_cnt_ff + 8'h01;
          rx_state_ff <= rx_more ? BTU_RX_ARMED : BTU_RX_IDLE;
          rx_done_ff  <= ~rx_more;
        end
      end
    end
  end

  always_ff @(posedge hclk) begin
    if (rx_eval & rx_ok) rxbuf_ff[rx_idx_ff] <= rx_char;
  end

  btu_interval_timer u_tx_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ctl     (tx_ctl),
    .tick    (tx_tick_event),
    .running (tx_running)
  );

  btu_interval_timer u_rx_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ctl     (rx_ctl),
    .tick    (rx_tick_event),
    .running (rx_running)
  );

  // Cycle counters since the last timer start or tick, read only by the checks below.
  logic [15:0] tx_gap_ff;
  logic [15:0] rx_gap_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_gap_ff <= 16'h0000;
      rx_gap_ff <= 16'h0000;
    end else begin
      tx_gap_ff <= (tx_ctl.start | tx_tick_event) ? 16'h0000 : tx_gap_ff + 16'h0001;
      rx_gap_ff <= (rx_ctl.start | rx_tick_event) ? 16'h0000 : rx_gap_ff + 16'h0001;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_TX_IDLE_LEVEL: assert property (!tx_busy && $past(!tx_busy) && $stable(cfg_ff)
    |-> serial_out_ff == ~cfg_ff.invert) else $error("Idle transmit level wrong.");
  AST_TX_FIRST_BIT: assert property (tx_go && tx_len_ff != 8'h00
    |=> serial_out_ff == $past(cfg_ff.invert) && tx_busy) else $error("First start bit late.");
  AST_TX_BIT_GAP: assert property (tx_step |-> tx_gap_ff == interval_ff - 16'h0001)
    else $error("Transmit bit period wrong.");
  AST_TX_STOP_HELD: assert property (tx_last && tx_more && interval_ff > 16'h0009
    |=> ##1 $stable(serial_out_ff) [*8]) else $error("Stop bit cut short.");
  AST_TX_DONE: assert property (tx_last && !tx_more
    |=> tx_done_ff && !tx_busy && !tx_running) else $error("Transmit end wrong.");
  AST_RX_EDGE: assert property (start_edge_detect |=> rx_state_ff == BTU_RX_RECV && rx_running)
    else $error("Start edge missed.");
  AST_RX_HALF: assert property (rx_step && rx_bits_ff == 4'h0
    |-> rx_gap_ff == {1'b0, interval_ff[15:1]} - 16'h0001) else $error("First sample not at half bit.");
  AST_RX_FULL: assert property (rx_step && rx_bits_ff != 4'h0
    |-> rx_gap_ff == interval_ff - 16'h0001) else $error("Sample period wrong.");
  AST_RX_HALT: assert property (rx_eval |=> !rx_running)
    else $error("Receive timer still running.");
  AST_RX_FE: assert property (rx_eval && rx_fe |=> framing_err_ff && !rx_busy)
    else $error("Framing error not recorded.");
  AST_RX_PE_OFF: assert property (rx_eval && !par_chk |=> $stable(parity_err_ff))
    else $error("Parity flagged without parity check.");
  AST_RX_STORE: assert property (rx_eval && rx_ok && rx_more
    |=> rx_cnt_ff == $past(rx_cnt_ff) + 8'h01 && rx_state_ff == BTU_RX_ARMED
        && rxbuf_ff[$past(rx_idx_ff)] == $past(rx_char)) else $error("Character store wrong.");
  AST_RX_DONE: assert property (rx_eval && rx_ok && !rx_more |=> rx_done_ff && !rx_busy)
    else $error("Reception complete not set.");
  // The stop bit sits at the idle level, so a finished frame leaves no glitch on the line.
  AST_TX_STOP_LEVEL: assert property (tx_last |=> serial_out_ff == ~cfg_ff.invert)
    else $error("Stop bit level wrong.");
  AST_RX_PE: assert property (rx_eval && rx_pe |=> parity_err_ff && !rx_busy)
    else $error("Parity error not recorded.");

  COV_TX_DONE: cover property (tx_last && !tx_more);
  COV_TX_BACK2BACK: cover property (tx_last && tx_more);
  COV_RX_GOOD: cover property (rx_eval && rx_ok);
  COV_RX_FE: cover property (rx_eval && rx_fe);
  COV_RX_PE: cover property (rx_eval && rx_pe);
endmodule

// [btu_map.svh]
// Register offsets, field positions, reset values and timing counts of the bit-timed UART.
`ifndef BTU_MAP_SVH
`define BTU_MAP_SVH
`define BTU_CLK_PERIOD_NS   8
`define BTU_BIT_TIME_NS     104000
`define BTU_BIT_CYCLES      (`BTU_BIT_TIME_NS / `BTU_CLK_PERIOD_NS)
`define BTU_OFF_CTRL        8'h00
`define BTU_OFF_CMD         8'h04
`define BTU_OFF_STATUS      8'h08
`define BTU_OFF_TX_LEN      8'h0C
`define BTU_OFF_RX_LEN      8'h10
`define BTU_OFF_INTERVAL    8'h14
`define BTU_BUF_TX          2'h1
`define BTU_BUF_RX          2'h2
`define BTU_CTRL_LSB        0
`define BTU_CTRL_INV        3
`define BTU_CTRL_RESET      4'h0
`define BTU_CMD_TX          0
`define BTU_CMD_RX          1
`define BTU_FRAME_NOPAR     4'hA
`define BTU_FRAME_PAR       4'hB
`define BTU_FRAME_IDLE      16'hFFFF
`endif

// [btu_pkg.sv]
// Types shared by the bit-timed UART modules.
package btu_pkg;
  typedef enum logic [1:0] {
    BTU_PAR_NONE = 2'h0,
    BTU_PAR_LOW  = 2'h1,
    BTU_PAR_ODD  = 2'h2,
    BTU_PAR_EVEN = 2'h3
  } btu_parity_e;
  typedef enum logic [1:0] {
    BTU_TX_IDLE = 2'h1,
    BTU_TX_RUN  = 2'h2
  } btu_tx_state_e;
  typedef enum logic [2:0] {
    BTU_RX_IDLE  = 3'h1,
    BTU_RX_ARMED = 3'h2,
    BTU_RX_RECV  = 3'h4
  } btu_rx_state_e;
  typedef struct packed {
    logic        invert;
    btu_parity_e parity;
    logic        lsb_first;
  } btu_cfg_s;
  typedef struct packed {
    logic        start;
    logic        stop;
    logic [15:0] start_load;
    logic [15:0] reload;
  } btu_timer_ctl_s;
endpackage

// [btu_interval_timer.sv]
// Interval timer that pulses a tick every loaded number of cycles.
module btu_interval_timer
  import btu_pkg::*;
(
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire btu_timer_ctl_s ctl,
  output logic                tick,
  output logic                running
);
  logic [15:0] cnt_ff;
  logic        run_ff;

  assign tick    = run_ff & (cnt_ff == 16'h0000);
  assign running = run_ff;

  // Start wins over stop so a frame can end and the next begin in one cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 16'h0000;
      run_ff <= 1'b0;
    end else if (ctl.start) begin
      run_ff <= 1'b1;
      cnt_ff <= ctl.start_load - 16'h0001;
    end else if (ctl.stop) begin
      run_ff <= 1'b0;
    end else if (tick) begin
      cnt_ff <= ctl.reload - 16'h0001;
    end else if (run_ff) begin
      cnt_ff <= cnt_ff - 16'h0001;
    end
  end
endmodule

// [btu_remote_model.sv]
// Behavioural remote serial device that sends frames and captures the block's frames.
module btu_remote_model (
  input  wire logic        hclk,
  input  wire logic        listen,
  input  wire logic        invert,
  input  wire logic [3:0]  nbits,
  input  wire logic [15:0] period,
  input  wire logic        serial_out_line,
  output logic             serial_in_line,
  output logic             got_valid,
  output logic [15:0]      got_frame
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] raw;
  initial begin
    serial_in_line = 1'b1;
    got_valid      = 1'b0;
    got_frame      = 16'h0000;
  end
  // The lead-in sits at the level opposite the first bit, so the start is a true edge.
  task automatic send(input logic [15:0] frame);
    serial_in_line <= invert;
    repeat (3) @(posedge hclk);
    for (int i = 0; i < nbits; i++) begin
      serial_in_line <= frame[i];
      repeat (period) @(posedge hclk);
    end
  endtask
  // Each level is taken mid-bit, so a stop bit cut short shows up as a wrong level.
  initial forever begin
    @(posedge hclk);
    if (listen === 1'b1 && serial_out_line !== ~invert) begin
      raw = 16'h0000;
      repeat (period / 2) @(posedge hclk);
      for (int i = 0; i < nbits; i++) begin
        raw[i] = serial_out_line;
        if (i < nbits - 1) repeat (period) @(posedge hclk);
      end
      got_frame <= raw;
      got_valid <= 1'b1;
      @(posedge hclk);
      got_valid <= 1'b0;
    end
  end
endmodule

// [test_bit_timed_uart_transceiver.sv]
// Self-checking bench for the bit-timed UART and its register port.
module test_bit_timed_uart_transceiver import btu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned BITS    = 32;
  localparam int          CEILING = 20000;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        serial_in_line, serial_out_line, listen, m_invert, got_valid;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  m_nbits;
  logic [15:0] m_period, got_frame;
  logic [15:0] exp_q[$];
  int          bad_count, comparisons, cycles, seed;
  assign hready = hreadyout;
  btu_uart_top #(.BIT_CYCLES(BITS), .DEPTH(16)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .serial_in_line(serial_in_line),
    .serial_out_line(serial_out_line));
  btu_remote_model remote (
    .hclk(hclk), .listen(listen), .invert(m_invert), .nbits(m_nbits), .period(m_period),
    .serial_out_line(serial_out_line), .serial_in_line(serial_in_line),
    .got_valid(got_valid), .got_frame(got_frame));
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One single-word transfer; the waits are left open and only the timeout ends them.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic poll(input logic [31:0] mask, output logic [31:0] st);
    int n;
    n = 0;
    do begin
      bus(1'b0, 8'h08, 32'h00000000, st);
      n++;
    end while ((st & mask) === 32'h00000000 && n < 1000);
  endtask
  function automatic logic [15:0] mk_frame(input logic [7:0] c, input btu_cfg_s cfg);
    logic [7:0]  d;
    logic        p;
    logic [15:0] f;
    if (cfg.lsb_first) d = c;
    else d = {<<{c}};
    p = (cfg.parity == BTU_PAR_EVEN) ? ^c : ((cfg.parity == BTU_PAR_ODD) ? ~^c : 1'b0);
    if (cfg.parity == BTU_PAR_NONE) f = {6'h00, 1'b1, d, 1'b0};
    else f = {5'h00, 1'b1, p, d, 1'b0};
    if (cfg.invert) f = f ^ ((cfg.parity == BTU_PAR_NONE) ? 16'h03FF : 16'h07FF);
    return f;
  endfunction
  task automatic setup(input btu_cfg_s cfg);
    listen <= 1'b0;
    wr(8'h00, {28'h0000000, cfg});
    repeat (2) @(posedge hclk);
    check({31'h00000000, serial_out_line}, {31'h00000000, ~cfg.invert});
    m_invert <= cfg.invert;
    m_nbits  <= (cfg.parity == BTU_PAR_NONE) ? 4'hA : 4'hB;
  endtask
  // Frames that reach the remote device are matched in order against the noted ones.
  always @(posedge hclk) begin
    if (got_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check({16'h0000, got_frame}, 32'hFFFFFFFF);
      end else begin
        check({16'h0000, got_frame}, {16'h0000, exp_q.pop_front()});
      end
    end
  end
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == CEILING) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    logic [31:0] rd;
    logic [31:0] st;
    logic [7:0]  ch [2];
    logic [7:0]  r_addr [5];
    logic [31:0] r_val [5];
    btu_cfg_s    cfg;
    int          n;
    seed = 74;
    bad_count = 0;
    comparisons = 0;
    cycles = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    listen = 1'b0;
    m_invert = 1'b0;
    m_nbits = 4'hA;
    m_period = 16'(BITS);
    r_addr = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h30};
    r_val = '{32'h00000000, 32'h00000000, 32'h00000000, 32'(BITS), 32'h00000000};
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    check({31'h00000000, serial_out_line}, 32'h00000001);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, r_addr[i], 32'h00000000, rd);
      check(rd, r_val[i]);
    end
    for (int k = 0; k < 4; k++) begin
      cfg.invert = k[1];
      cfg.parity = btu_parity_e'(k[1:0]);
      cfg.lsb_first = k[0];
      setup(cfg);
      listen <= 1'b1;
      for (int j = 0; j < 2; j++) begin
        ch[j] = 8'($random(seed));
        wr(8'(8'h40 + 4 * j), {24'h000000, ch[j]});
        exp_q.push_back(mk_frame(ch[j], cfg));
      end
      wr(8'h0C, 32'h00000002);
      wr(8'h04, 32'h00000001);
      poll(32'h00000002, st);
      check(st & 32'h00FF0003, 32'h00020002);
      n = 0;
      while (exp_q.size() != 0 && n < 4 * BITS) begin
        @(posedge hclk);
        n++;
      end
      check(32'(exp_q.size()), 32'h00000000);
    end
    // Odd parity, high bit first, true polarity: a bad parity bit, then a bad stop bit.
    // Last, fixed-low parity, where a wrong parity bit must pass unchecked.
    for (int e = 0; e < 3; e++) begin
      cfg = btu_cfg_s'((e == 2) ? 4'h2 : 4'h4);
      setup(cfg);
      wr(8'h10, 32'h00000001);
      wr(8'h04, 32'h00000002);
      ch[0] = 8'($random(seed));
      remote.send(mk_frame(ch[0], cfg) ^ 16'h0001 ^ ((e == 1) ? 16'h0400 : 16'h0200));
      poll(32'h00000038, st);
      rd = (e == 0) ? 32'h00000020 : ((e == 1) ? 32'h00000010 : 32'h00000108);
      check(st & 32'h0000FF3C, rd);
    end
    bus(1'b0, 8'h80, 32'h00000000, rd);
    check(rd, {24'h000000, ch[0]});
    // Even parity, low bit first, flipped polarity: two good characters.
    setup(4'hF);
    wr(8'h10, 32'h00000002);
    wr(8'h04, 32'h00000002);
    for (int j = 0; j < 2; j++) begin
      ch[j] = 8'($random(seed));
      remote.send(mk_frame(ch[j], 4'hF) ^ 16'h0001);
    end
    poll(32'h00000008, st);
    check(st & 32'h0000FF3C, 32'h00000208);
    for (int j = 0; j < 2; j++) begin
      bus(1'b0, 8'(8'h80 + 4 * j), 32'h00000000, rd);
      check(rd, {24'h000000, ch[j]});
    end
    give_verdict();
  end
endmodule
